// ---- src/clk_pwr_pkg.sv ----
// Constants and types for the clock, reset and power-mode controller
package clk_pwr_pkg;

    // Register map, byte addresses on the 8-bit register port
    localparam logic [3:0] ADDR_CLKSEL   = 4'h0;
    localparam logic [3:0] ADDR_LOOPCFG  = 4'h1;
    localparam logic [3:0] ADDR_REFDIV   = 4'h2;
    localparam logic [3:0] ADDR_POSTDIV  = 4'h3;
    localparam logic [3:0] ADDR_STATUS   = 4'h4;
    localparam logic [3:0] ADDR_WDOGCTL  = 4'h5;
    localparam logic [3:0] ADDR_TRIM_LO  = 4'h6;
    localparam logic [3:0] ADDR_TRIM_HI  = 4'h7;
    localparam logic [3:0] ADDR_RSTFLAG  = 4'h8;

    // CLKSEL fields
    localparam int BIT_BUS_SRC   = 0;
    localparam int BIT_OSC_EN    = 1;
    localparam int BIT_PSTOP     = 2;
    localparam int BIT_WD_SEL0   = 3;
    localparam int BIT_WD_SEL1   = 4;
    localparam int BIT_TICK_SEL  = 5;
    localparam int BIT_PS_WD_EN  = 6;
    localparam int BIT_PS_TK_EN  = 7;
    // WDOGCTL fields
    localparam int BIT_DBG_FRZ   = 7;
    localparam int BIT_WD_SDIS   = 6;
    // STATUS fields
    localparam int BIT_OSC_UP    = 0;
    localparam int BIT_LOCK      = 1;
    localparam int BIT_LOCK_IRQ  = 2;
    localparam int BIT_IN_STOP   = 3;
    localparam int BIT_PSEUDO    = 4;

    // Reset values, plus the watchdog rate forced in debug
    localparam logic [7:0] CLKSEL_RST   = 8'h01;
    localparam logic [7:0] LOOPCFG_RST  = 8'h58;
    localparam logic [7:0] REFDIV_RST   = 8'h00;
    localparam logic [7:0] POSTDIV_RST  = 8'h03;
    localparam logic [7:0] WDOGCTL_RST  = 8'h00;
    localparam logic [2:0] WD_RATE_MAX  = 3'h7;

    // Reset sources in flag register order
    localparam int NUM_RST_SRC = 7;
    localparam int RS_POR  = 0;
    localparam int RS_LVR  = 1;
    localparam int RS_WDT  = 2;
    localparam int RS_WWIN = 3;
    localparam int RS_OSCM = 4;
    localparam int RS_LPM  = 5;
    localparam int RS_PIN  = 6;

    // Reset pin drive stretch
    localparam int RST_DRIVE_NS  = 1000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RST_DRIVE_CYC = (RST_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ST_RUN     = 4'b0001,
        ST_FULL    = 4'b0010,
        ST_PSEUDO  = 4'b0100,
        ST_WAKE    = 4'b1000
    } pmode_type;

endpackage : clk_pwr_pkg

// ---- src/clk_pwr_ctrl.sv ----
// Clock source select, power modes, timer clock gating and reset collection
module clk_pwr_ctrl
    import clk_pwr_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // CPU events
    input  wire logic        stop_instr,
    input  wire logic        wake_event,
    input  wire logic        debug_active,
    input  wire logic        wait_instr,
    // Analog status, asynchronous
    input  wire logic        crystal_osc_up_status,
    input  wire logic        loop_lock_raw,
    input  wire logic        por_event,
    input  wire logic        lvr_event,
    input  wire logic        wdt_timeout,
    input  wire logic        wdt_window_err,
    input  wire logic        osc_monitor_fail,
    input  wire logic        loop_monitor_fail,
    // Factory trim from flash
    input  wire logic [15:0] flash_trim,
    input  wire logic        flash_trim_valid,
    // Reset pin, three signals
    input  wire logic        reset_pin_n_in,
    output logic             reset_pin_n_out,
    output logic             reset_pin_n_oe,
    // Clock tree controls
    output logic             bus_from_loop,
    output logic             bus_clk_run,
    output logic             loop_enable,
    output logic             irc_enable,
    output logic             crystal_osc_enable,
    output logic             loop_ref_from_crystal,
    output logic [7:0]       loop_config,
    output logic [3:0]       reference_divider_field,
    output logic [4:0]       post_divider,
    output logic [15:0]      internal_reference_trim,
    // Regulator and monitors
    output logic             regulator_full_performance,
    output logic             low_voltage_monitor_en,
    output logic             autonomous_periodic_interrupt_en,
    // Timer clocking
    output logic             watchdog_clk_en,
    output logic [1:0]       watchdog_clk_src,
    output logic             tick_clk_en,
    output logic             tick_clk_from_osc,
    output logic             watchdog_force_max,
    output logic [2:0]       watchdog_rate_field,
    output logic             watchdog_stop_latency,
    // Interrupt request and system reset
    output logic             lock_irq,
    output logic             system_reset
);

    pmode_type   mode_r;
    logic [7:0]  clksel_r;
    logic [7:0]  loopcfg_r;
    logic [7:0]  refdiv_r;
    logic [7:0]  postdiv_r;
    logic [7:0]  wdogctl_r;
    logic [15:0] trim_r;
    logic        trim_loaded_r;
    logic [NUM_RST_SRC-1:0] rst_flag_r;
    logic        lock_irq_r;
    logic        lock_prev_r;
    logic [7:0]  rdata_r;
    logic [5:0]  drive_cnt_r;
    logic        wd_lat_r;

    // Write strobe decode shared by the CLKSEL, STATUS, TRIM and RSTFLAG writes
    function automatic logic wr_hit(input logic wr, input logic [3:0] addr,
                                    input logic [3:0] target);
        return wr && (addr == target);
    endfunction : wr_hit

    // Two-flop synchronisers for everything from outside the clock domain
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;

    // Pin level inverted so a low pin reads as an active source
    assign async_in = {~reset_pin_n_in, loop_monitor_fail, osc_monitor_fail,
                       wdt_window_err, wdt_timeout, lvr_event, por_event,
                       loop_lock_raw, crystal_osc_up_status, flash_trim_valid};

    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end

    logic trim_valid_s, osc_up_s, lock_s;
    logic [NUM_RST_SRC-1:0] rst_src_s;
    assign trim_valid_s = sync2_r[0];
    assign osc_up_s     = sync2_r[1];
    assign lock_s       = sync2_r[2];
    assign rst_src_s    = sync2_r[9:3];

    // Stop covers both flavours; the wake state already counts as running
    logic in_stop, pseudo_sel;
    assign in_stop    = (mode_r == ST_FULL) || (mode_r == ST_PSEUDO);
    assign pseudo_sel = clksel_r[BIT_PSTOP] && clksel_r[BIT_OSC_EN];

    // stop entry only by instruction; wait ignored
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_r <= ST_RUN;
        end else begin
            case (mode_r)
                ST_RUN: begin
                    if (stop_instr) begin
                        mode_r <= pseudo_sel ? ST_PSEUDO : ST_FULL;
                    end
                end
                ST_FULL, ST_PSEUDO: begin
                    if (wake_event) begin
                        mode_r <= ST_WAKE;
                    end
                end
                // One settling cycle before a second stop is honoured
                ST_WAKE: begin
                    mode_r <= ST_RUN;
                end
                default: begin
                    mode_r <= ST_RUN;
                end
            endcase
        end
    end

    logic wr_clksel;
    assign wr_clksel = wr_hit(reg_wr, reg_addr, ADDR_CLKSEL) && !in_stop;

    // reset selects loop; restore only on full stop
    always_ff @(posedge mclk) begin
        if (reset) begin
            clksel_r <= CLKSEL_RST;
        end else if (stop_instr && mode_r == ST_RUN && !pseudo_sel) begin
            // applied on entry so the wake sees loop and internal clocks
            clksel_r[BIT_BUS_SRC]  <= 1'b1;
            clksel_r[BIT_WD_SEL0]  <= 1'b0;
            clksel_r[BIT_TICK_SEL] <= 1'b0;
        end else if (wr_clksel) begin
            // software clears bus select for bypass
            clksel_r <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            loopcfg_r <= LOOPCFG_RST;
            refdiv_r  <= REFDIV_RST;
            postdiv_r <= POSTDIV_RST;
            wdogctl_r <= WDOGCTL_RST;
        end else if (reg_wr && !in_stop) begin
            case (reg_addr)
                ADDR_LOOPCFG: loopcfg_r <= reg_wdata;
                ADDR_REFDIV:  refdiv_r  <= {4'h0, reg_wdata[3:0]};
                ADDR_POSTDIV: postdiv_r <= {3'h0, reg_wdata[4:0]};
                ADDR_WDOGCTL: wdogctl_r <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // trim load once after reset, software overwrite later wins
    always_ff @(posedge mclk) begin
        if (reset) begin
            trim_r        <= 16'h0000;
            trim_loaded_r <= 1'b0;
        end else if (wr_hit(reg_wr, reg_addr, ADDR_TRIM_LO)) begin
            trim_r[7:0]   <= reg_wdata;
            trim_loaded_r <= 1'b1;
        end else if (wr_hit(reg_wr, reg_addr, ADDR_TRIM_HI)) begin
            trim_r[15:8]  <= reg_wdata;
            trim_loaded_r <= 1'b1;
        end else if (!trim_loaded_r && trim_valid_s) begin
            trim_r        <= flash_trim;
            trim_loaded_r <= 1'b1;
        end
    end

    // Edge taken on the synchronised level; sub-cycle glitches are lost
    // lock changes raise a sticky request; set beats clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            lock_prev_r <= 1'b0;
            lock_irq_r  <= 1'b0;
        end else begin
            lock_prev_r <= lock_s;
            if (lock_s != lock_prev_r) begin
                lock_irq_r <= 1'b1;
            end else if (wr_hit(reg_wr, reg_addr, ADDR_STATUS) && reg_wdata[BIT_LOCK_IRQ]) begin
                lock_irq_r <= 1'b0;
            end
        end
    end

    // reset sources collected; flags survive the resulting reset
    logic any_src;
    assign any_src = |rst_src_s;

    // No reset branch: the flags must outlive the reset they report
    // They read unknown until the first power-on event sets them
    always_ff @(posedge mclk) begin
        if (rst_src_s[RS_POR]) begin
            rst_flag_r <= 7'h01;
        end else if (any_src) begin
            rst_flag_r <= rst_flag_r | rst_src_s;
        end else if (wr_hit(reg_wr, reg_addr, ADDR_RSTFLAG)) begin
            rst_flag_r <= rst_flag_r & ~reg_wdata[NUM_RST_SRC-1:0];
        end
    end

    // Pin loops back through the synchroniser, so internal resets flag it too
    // stretch internal reset onto the open-drain pin
    logic internal_src;
    assign internal_src = |rst_src_s[RS_LPM:RS_POR];

    always_ff @(posedge mclk) begin
        if (reset) begin
            drive_cnt_r <= 6'h00;
        end else if (internal_src) begin
            drive_cnt_r <= 6'(RST_DRIVE_CYC);
        end else if (drive_cnt_r != 6'h00) begin
            drive_cnt_r <= drive_cnt_r - 6'h01;
        end
    end

    // One-cycle pulse warns the watchdog of the gap in its RC clock
    // RC-clocked watchdog latency flag on stop entry and exit
    always_ff @(posedge mclk) begin
        if (reset) begin
            wd_lat_r <= 1'b0;
        end else begin
            wd_lat_r <= clksel_r[BIT_WD_SEL1] && wdogctl_r[BIT_WD_SDIS]
                        && ((mode_r == ST_RUN && stop_instr) || mode_r == ST_WAKE);
        end
    end

    // Register read, data in the next cycle
    // Idle returns zero so a stale byte never looks like an answer
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CLKSEL:  rdata_r <= clksel_r;
                ADDR_LOOPCFG: rdata_r <= loopcfg_r;
                ADDR_REFDIV:  rdata_r <= refdiv_r;
                ADDR_POSTDIV: rdata_r <= postdiv_r;
                ADDR_STATUS:  rdata_r <= {3'h0, mode_r == ST_PSEUDO, in_stop,
                                          lock_irq_r, lock_s, osc_up_s};
                ADDR_WDOGCTL: rdata_r <= wdogctl_r;
                ADDR_TRIM_LO: rdata_r <= trim_r[7:0];
                ADDR_TRIM_HI: rdata_r <= trim_r[15:8];
                ADDR_RSTFLAG: rdata_r <= {1'b0, rst_flag_r};
                default:      rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;

    // system reset covers every source including the pin
    assign system_reset    = any_src;
    assign reset_pin_n_out = 1'b0;
    assign reset_pin_n_oe  = internal_src || (drive_cnt_r != 6'h00);

    // Loop stays on in bypass because it qualifies the crystal clock
    // bypass keeps loop running; stop turns off loop, reference, bus
    assign bus_from_loop         = clksel_r[BIT_BUS_SRC];
    assign bus_clk_run           = !in_stop;
    assign loop_enable           = !in_stop;
    assign irc_enable            = !in_stop;
    // full stop disables the crystal; pseudo keeps it
    assign crystal_osc_enable    = clksel_r[BIT_OSC_EN] && (mode_r != ST_FULL);
    assign loop_ref_from_crystal = clksel_r[BIT_OSC_EN];
    assign loop_config             = loopcfg_r;
    assign reference_divider_field = refdiv_r[3:0];
    assign post_divider            = postdiv_r[4:0];
    assign internal_reference_trim = trim_r;

    assign regulator_full_performance       = !in_stop;
    assign low_voltage_monitor_en           = !in_stop;
    assign autonomous_periodic_interrupt_en = 1'b1;

    // Forced maximum only when not frozen; a frozen watchdog needs no margin
    // debug freeze; max period in debug
    logic frozen;
    assign frozen             = debug_active && wdogctl_r[BIT_DBG_FRZ];
    assign watchdog_force_max = debug_active && !wdogctl_r[BIT_DBG_FRZ];
    assign watchdog_rate_field = watchdog_force_max ? WD_RATE_MAX : wdogctl_r[2:0];
    assign watchdog_clk_src   = {clksel_r[BIT_WD_SEL1], clksel_r[BIT_WD_SEL0]};
    assign watchdog_stop_latency = wd_lat_r;

    // Freeze only matters while running; in stop the mode decides
    // watchdog clock per mode
    always_comb begin
        watchdog_clk_en = !frozen;
        if (in_stop) begin
            if (clksel_r[BIT_WD_SEL1]) begin
                watchdog_clk_en = !wdogctl_r[BIT_WD_SDIS];
            end else if (mode_r == ST_PSEUDO) begin
                watchdog_clk_en = clksel_r[BIT_PS_WD_EN];
            end else begin
                watchdog_clk_en = 1'b0;
            end
        end
    end

    // Pseudo stop ticks from the crystal when its tick enable bit is set, the internal clock is off
    // full stop halts tick; pseudo on crystal if enabled
    always_comb begin
        tick_clk_en       = !frozen;
        tick_clk_from_osc = clksel_r[BIT_TICK_SEL];
        if (mode_r == ST_FULL) begin
            tick_clk_en = 1'b0;
        end else if (mode_r == ST_PSEUDO) begin
            tick_clk_en       = clksel_r[BIT_PS_TK_EN];
            tick_clk_from_osc = 1'b1;
        end
    end

    assign lock_irq = lock_irq_r;

endmodule : clk_pwr_ctrl

// ---- dv/clk_pwr_ctrl_checker.sv ----
// Port-level assertions for the clock and power-mode controller
module clk_pwr_ctrl_checker (
    // Clock and reset
    input wire logic       mclk, reset,
    // Watched ports
    input wire logic       stop_instr, debug_active, loop_lock_raw, wdt_timeout,
    input wire logic       bus_from_loop, bus_clk_run, loop_enable, irc_enable,
    input wire logic       crystal_osc_enable, loop_ref_from_crystal,
    input wire logic [4:0] post_divider,
    input wire logic       regulator_full_performance, low_voltage_monitor_en,
    input wire logic       autonomous_periodic_interrupt_en, tick_clk_en, watchdog_clk_en,
    input wire logic       watchdog_force_max, lock_irq, system_reset,
    input wire logic       reset_pin_n_out, reset_pin_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_reset_start: assert property ($fell(reset) |-> bus_from_loop
        && !loop_ref_from_crystal && post_divider == 5'h03) else $error("bad start mode");
    a_stop_instr: assert property ($fell(bus_clk_run) |-> $past(stop_instr))
        else $error("stop without instruction");
    a_stop_clocks_off: assert property (stop_instr && bus_clk_run |=>
        !bus_clk_run && !loop_enable && !irc_enable && autonomous_periodic_interrupt_en)
        else $error("stop clocks not off");
    a_stop_regulator: assert property (stop_instr && bus_clk_run |=>
        !regulator_full_performance && !low_voltage_monitor_en) else $error("stop regulator");
    a_run_full: assert property (bus_clk_run |-> regulator_full_performance
        && low_voltage_monitor_en && loop_enable && irc_enable) else $error("run not full");
    a_full_tick_halt: assert property (stop_instr && bus_clk_run ##1 !crystal_osc_enable
        |-> !tick_clk_en) else $error("tick runs in full stop");
    a_bypass_loop: assert property (!bus_from_loop && bus_clk_run |-> loop_enable)
        else $error("loop off in bypass");
    a_debug_freeze: assert property (debug_active && bus_clk_run && !watchdog_force_max
        |-> !watchdog_clk_en && !tick_clk_en) else $error("timers not frozen");
    a_lock_irq: assert property ($rose(loop_lock_raw) |-> ##[1:4] lock_irq)
        else $error("no lock interrupt");
    a_reset_source: assert property ($rose(wdt_timeout) |-> ##[1:4] system_reset)
        else $error("no system reset");
    a_pin_drive: assert property ($rose(wdt_timeout) |-> ##[1:4]
        (reset_pin_n_oe && !reset_pin_n_out)) else $error("reset pin not driven");

    c_stop: cover property (stop_instr && bus_clk_run);
    c_lock: cover property ($rose(lock_irq));
    c_sysrst: cover property (system_reset);
    c_force: cover property (debug_active && watchdog_force_max);
endmodule : clk_pwr_ctrl_checker

bind clk_pwr_ctrl clk_pwr_ctrl_checker u_clk_pwr_ctrl_checker (
    .mclk, .reset, .stop_instr, .debug_active, .loop_lock_raw, .wdt_timeout,
    .bus_from_loop, .bus_clk_run, .loop_enable, .irc_enable, .crystal_osc_enable,
    .loop_ref_from_crystal, .post_divider, .regulator_full_performance,
    .low_voltage_monitor_en, .autonomous_periodic_interrupt_en, .tick_clk_en,
    .watchdog_clk_en, .watchdog_force_max, .lock_irq, .system_reset,
    .reset_pin_n_out, .reset_pin_n_oe);

// ---- dv/osc_loop_model.sv ----
// Crystal oscillator and loop lock model
module osc_loop_model #(
    parameter int UP_CYC   = 20,
    parameter int LOCK_CYC = 30
) (
    input wire logic mclk, crystal_osc_enable, loop_enable,
    output logic     crystal_osc_up_status, loop_lock_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    int osc_cnt = 0;
    int lock_cnt = 0;

    always @(posedge mclk) begin
        osc_cnt <= (crystal_osc_enable !== 1'b1) ? 0
                   : (osc_cnt < UP_CYC ? osc_cnt + 1 : osc_cnt);
        lock_cnt <= (loop_enable !== 1'b1) ? 0
                    : (lock_cnt < LOCK_CYC ? lock_cnt + 1 : lock_cnt);
    end
    assign crystal_osc_up_status = (osc_cnt == UP_CYC);
    assign loop_lock_raw = (lock_cnt == LOCK_CYC);
endmodule : osc_loop_model

// ---- dv/test_clk_pwr_ctrl.sv ----
// Register-driven testbench for the clock and power-mode controller
module test_clk_pwr_ctrl import clk_pwr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, debug_active = 1'b0;
    logic        stop_instr = 1'b0, wake_event = 1'b0, wait_instr = 1'b0;
    logic [3:0]  reg_addr = 4'h0, reference_divider_field;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, d, loop_config;
    logic [6:0]  src = 7'h00;
    logic [4:0]  post_divider;
    logic [15:0] internal_reference_trim, flash_trim = 16'hA5C3;
    logic [1:0]  watchdog_clk_src;
    logic [2:0]  watchdog_rate_field;
    logic        crystal_osc_up_status, loop_lock_raw, reset_pin_n_in, reset_pin_n_out;
    logic        reset_pin_n_oe, bus_from_loop, bus_clk_run, loop_enable, irc_enable;
    logic        crystal_osc_enable, loop_ref_from_crystal, regulator_full_performance;
    logic        low_voltage_monitor_en, autonomous_periodic_interrupt_en, watchdog_clk_en;
    logic        tick_clk_en, tick_clk_from_osc, watchdog_force_max, watchdog_stop_latency;
    logic        lock_irq, system_reset;
    logic        flash_trim_valid = 1'b0;
    int          err_total = 0, total_checks = 0, cyc = 0;

    // Open-drain pin with pull-up
    assign reset_pin_n_in = (reset_pin_n_oe ? reset_pin_n_out : 1'b1) && !src[RS_PIN];
    always #20 mclk = ~mclk;

    clk_pwr_ctrl u_clk_pwr_ctrl (
        .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_instr,
        .wake_event, .debug_active, .wait_instr, .crystal_osc_up_status, .loop_lock_raw,
        .por_event(src[RS_POR]), .lvr_event(src[RS_LVR]), .wdt_timeout(src[RS_WDT]),
        .wdt_window_err(src[RS_WWIN]), .osc_monitor_fail(src[RS_OSCM]),
        .loop_monitor_fail(src[RS_LPM]), .flash_trim, .flash_trim_valid,
        .reset_pin_n_in, .reset_pin_n_out, .reset_pin_n_oe, .bus_from_loop, .bus_clk_run,
        .loop_enable, .irc_enable, .crystal_osc_enable, .loop_ref_from_crystal, .loop_config,
        .reference_divider_field, .post_divider, .internal_reference_trim,
        .regulator_full_performance, .low_voltage_monitor_en, .autonomous_periodic_interrupt_en,
        .watchdog_clk_en, .watchdog_clk_src, .tick_clk_en, .tick_clk_from_osc,
        .watchdog_force_max, .watchdog_rate_field, .watchdog_stop_latency, .lock_irq,
        .system_reset);

    osc_loop_model u_osc_loop_model (
        .mclk, .crystal_osc_enable, .loop_enable, .crystal_osc_up_status, .loop_lock_raw);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk

    task automatic chb(input logic seen, input logic exp);
        chk({15'h0000, seen}, {15'h0000, exp});
    endtask : chb

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
        chk({8'h00, d & m}, {8'h00, e});
    endtask : rdc

    // Event pulse: 0 stop, 1 wake, 2 wait; wake passes one extra state
    task automatic ev(input int k);
        @(posedge mclk);
        stop_instr <= (k == 0);
        wake_event <= (k == 1);
        wait_instr <= (k == 2);
        @(posedge mclk);
        stop_instr <= 1'b0;
        wake_event <= 1'b0;
        wait_instr <= 1'b0;
        repeat ((k == 1) ? 2 : 1) @(negedge mclk);
    endtask : ev

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        flash_trim_valid <= 1'b1;
        repeat (4) @(negedge mclk);
        chk({11'h000, post_divider}, 16'h0003);
        chb(loop_ref_from_crystal, 1'b0);
        rdc(ADDR_CLKSEL, 8'hFF, 8'h01);
        rdc(ADDR_LOOPCFG, 8'hFF, 8'h58);
        rdc(ADDR_POSTDIV, 8'hFF, 8'h03);
        chk(internal_reference_trim, 16'hA5C3);
        rdc(ADDR_TRIM_HI, 8'hFF, 8'hA5);
        wr(ADDR_TRIM_LO, 8'h11);
        rdc(ADDR_TRIM_LO, 8'hFF, 8'h11);
        wr(4'hF, 8'h55);
        rdc(4'hF, 8'hFF, 8'h00);
        repeat (40) @(negedge mclk);
        rdc(ADDR_STATUS, 8'h07, 8'h06);
        wr(ADDR_STATUS, 8'h04);
        rdc(ADDR_STATUS, 8'h07, 8'h02);
        $display("reset and lock test done");
        wr(ADDR_CLKSEL, 8'h03);
        repeat (30) @(negedge mclk);
        rdc(ADDR_STATUS, 8'h03, 8'h03);
        wr(ADDR_REFDIV, 8'hF5);
        chk({12'h000, reference_divider_field}, 16'h0005);
        rdc(ADDR_REFDIV, 8'hFF, 8'h05);
        wr(ADDR_CLKSEL, 8'h02);
        chb(bus_from_loop, 1'b0);
        chb(loop_enable, 1'b1);
        // Oscillator has been up about 18 cycles, since the end of its 20-cycle start-up time
        wr(ADDR_CLKSEL, 8'h8E);
        ev(0);
        chb(crystal_osc_enable, 1'b1);
        chb(tick_clk_from_osc, 1'b1);
        chb(tick_clk_en, 1'b1);
        rdc(ADDR_STATUS, 8'h18, 8'h18);
        ev(1);
        rdc(ADDR_CLKSEL, 8'hFF, 8'h8E);
        wr(ADDR_CLKSEL, 8'h2A);
        ev(0);
        chb(crystal_osc_enable, 1'b0);
        chb(watchdog_clk_en, 1'b0);
        chb(tick_clk_en, 1'b0);
        chb(low_voltage_monitor_en, 1'b0);
        rdc(ADDR_STATUS, 8'h18, 8'h08);
        ev(1);
        rdc(ADDR_CLKSEL, 8'hFF, 8'h03);
        wr(ADDR_CLKSEL, 8'h11);
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_WDOGCTL, (s == 1) ? 8'h40 : 8'h00);
            ev(0);
            chb(watchdog_clk_en, s == 0);
            chb(watchdog_stop_latency, s == 1);
            chb(tick_clk_en, 1'b0);
            ev(1);
            chb(watchdog_stop_latency, s == 1);
        end
        ev(2);
        chb(bus_clk_run, 1'b1);
        $display("power mode test done");
        wr(ADDR_WDOGCTL, 8'h80);
        @(posedge mclk);
        debug_active <= 1'b1;
        @(negedge mclk);
        chb(tick_clk_en, 1'b0);
        chb(watchdog_clk_en, 1'b0);
        @(posedge mclk);
        debug_active <= 1'b0;
        @(negedge mclk);
        chb(tick_clk_en, 1'b1);
        @(posedge mclk);
        debug_active <= 1'b1;
        wr(ADDR_WDOGCTL, 8'h03);
        chb(watchdog_force_max, 1'b1);
        chk({13'h0000, watchdog_rate_field}, {13'h0000, WD_RATE_MAX});
        @(posedge mclk);
        debug_active <= 1'b0;
        @(negedge mclk);
        chb(watchdog_force_max, 1'b0);
        for (int i = 0; i < NUM_RST_SRC; i++) begin
            @(posedge mclk);
            src <= 7'(1 << i);
            repeat (4) @(negedge mclk);
            chb(system_reset, 1'b1);
            chb(reset_pin_n_oe, i != RS_PIN);
            @(posedge mclk);
            src <= 7'h00;
            repeat (40) @(negedge mclk);
            rdc(ADDR_RSTFLAG, 8'(1 << i), 8'(1 << i));
            wr(ADDR_RSTFLAG, 8'h7F);
        end
        $display("debug and reset source test done");
        results();
    end
endmodule : test_clk_pwr_ctrl
